// ==== core/strap_cfg_pkg.sv ====
// package: register map, field layout and carrier types of the strap decoder
package strap_cfg_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] drv_tristate_off = 8'h00;
    localparam logic [7:0] cfg_status_off = 8'h04;
    localparam logic [7:0] sel_count_off = 8'h08;

    // ------------------------------------------------------------------
    // field positions in the status word
    // ------------------------------------------------------------------
    localparam int st_host_mode_pos = 0;
    localparam int st_unipolar_pos = 1;
    localparam int st_drv_en_pos = 2;
    localparam int st_sel_active_pos = 3;
    localparam int st_cfg_pos = 8;
    localparam int st_drv_active_pos = 16;

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [3:0] drv_tristate_rst = 4'h0;
    localparam logic [15:0] sel_count_rst = 16'h0000;
    localparam logic [15:0] sel_count_one = 16'h0001;

    // ------------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [1:0] htrans_seq = 2'h3;
    localparam logic [2:0] hsize_word = 3'h2;
    localparam logic [1:0] hresp_okay = 2'h0;

    // decoded configuration carried to the datapath
    typedef struct packed {
        logic ja_in_tx;
        logic ja_in_rx;
        logic bus_rd_wr_style;
        logic zero_sub_en;
        logic ami_en;
    } line_cfg_type;

    localparam line_cfg_type line_cfg_rst = '{
        ja_in_tx: 1'b0,
        ja_in_rx: 1'b0,
        bus_rd_wr_style: 1'b0,
        zero_sub_en: 1'b0,
        ami_en: 1'b0
    };

    // one latched bus address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bus_req_type;

    localparam bus_req_type bus_req_rst = '{valid: 1'b0, write: 1'b0, addr: 8'h00};

endpackage

// ==== core/strap_config_and_driver_enable.sv ====
// strap decoder, host select watcher and line driver enable with ahb-lite registers
//
// Contract
// - attenuator placement: low tx, high rx, float off
// - bus style pin: low strobes, high rd/wr
// - line code low, unipolar data: zero substitution codes enabled
// - line code high, unipolar data: plain ami, transparent
// - global enable low tristates all drivers immediately
// - other logic keeps running while drivers off
// - software tristate bit turns off its port in host mode only
`timescale 1ns/10ps

module strap_config_and_driver_enable
    import strap_cfg_pkg::*;
#(
    parameter int num_ports = 4
) (
    input wire logic mclk_i,                           // system clock, 250 mhz
    input wire logic arst_n_i,                         // async reset, active low
    input wire logic host_mode_i,                      // 1 host mode, 0 hardware mode
    input wire logic unipolar_i,                       // 1 unipolar data in hardware mode
    input wire logic host_select_n_i,                  // host interface select, active low
    input wire logic attenuator_place_select_i,        // placement level when driven
    input wire logic attenuator_place_float_i,         // 1 when placement pin undriven
    input wire logic bus_style_or_line_code_select_i,  // bus style or line code pin
    input wire logic global_drv_en_i,                  // global driver enable, high = on
    input wire logic hsel_i,                           // ahb slave select
    input wire logic [31:0] haddr_i,                   // ahb address
    input wire logic [1:0] htrans_i,                   // ahb transfer type
    input wire logic hwrite_i,                         // ahb write
    input wire logic [2:0] hsize_i,                    // ahb size
    input wire logic [31:0] hwdata_i,                  // ahb write data
    input wire logic hready_i,                         // ahb bus ready
    output logic [31:0] hrdata_o,                      // ahb read data
    output logic hreadyout_o,                          // ahb slave ready
    output logic [1:0] hresp_o,                        // ahb response
    output line_cfg_type line_cfg_o,                   // decoded configuration
    output logic host_access_o,                        // select active in host mode
    output logic [num_ports-1:0] line_out_tip_en_o,    // tip driver enable per port
    output logic [num_ports-1:0] line_out_ring_en_o    // ring driver enable per port
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    function automatic logic is_transfer(input logic [1:0] t);
        is_transfer = (t == htrans_nonseq) || (t == htrans_seq);
    endfunction

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [num_ports-1:0] port_driver_tristate_bit_reg;
    logic [num_ports-1:0] port_driver_tristate_bit_next;
    bus_req_type bus_req_reg;
    bus_req_type bus_req_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    line_cfg_type line_cfg_reg;
    line_cfg_type line_cfg_next;
    logic sel_n_reg;
    logic sel_n_next;
    logic host_access_reg;
    logic host_access_next;
    logic [15:0] sel_count_reg;
    logic [15:0] sel_count_next;

    logic addr_phase;
    logic addr_ok;
    logic wr_tristate;
    logic wr_count_clear;
    logic sel_fall;
    logic [num_ports-1:0] drv_active;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // strap and host pin decode
    // ------------------------------------------------------------------
    // one mode at a time, so a shared pin never carries both meanings
    function automatic line_cfg_type decode_pins(
            input logic host_mode,
            input logic unipolar,
            input logic place,
            input logic place_open,
            input logic shared_pin);
        decode_pins = line_cfg_rst;
        if (host_mode) begin
            // host mode: the shared pin picks the bus style only
            decode_pins.bus_rd_wr_style = shared_pin;
        end else begin
            // hardware mode: attenuator and line code straps only
            // an open placement pin keeps the attenuator out of both paths
            if (!place_open) begin
                decode_pins.ja_in_tx = !place;
                decode_pins.ja_in_rx = place;
            end
            // the line code only means something for unipolar data
            if (unipolar) begin
                decode_pins.zero_sub_en = !shared_pin;
                decode_pins.ami_en = shared_pin;
            end
        end
    endfunction

    always_comb begin
        line_cfg_next = decode_pins(host_mode_i, unipolar_i, attenuator_place_select_i,
            attenuator_place_float_i, bus_style_or_line_code_select_i);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_cfg_reg <= line_cfg_rst;
        end else begin
            line_cfg_reg <= line_cfg_next;
        end
    end

    // ------------------------------------------------------------------
    // host select watcher
    // ------------------------------------------------------------------
    // each falling edge of the select in host mode starts one access
    assign sel_fall = host_mode_i && sel_n_reg && !host_select_n_i;

    always_comb begin
        sel_n_next = host_select_n_i;
        host_access_next = host_mode_i && !host_select_n_i;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            // idle level of the select, so no false edge follows reset
            sel_n_reg <= 1'b1;
            host_access_reg <= 1'b0;
        end else begin
            sel_n_reg <= sel_n_next;
            host_access_reg <= host_access_next;
        end
    end

    // ------------------------------------------------------------------
    // select fall counter
    // ------------------------------------------------------------------
    always_comb begin
        sel_count_next = sel_count_reg;
        if (wr_count_clear) begin
            sel_count_next = sel_count_rst;
        end
        // a new access in the clearing cycle still counts
        if (sel_fall) begin
            sel_count_next = wr_count_clear ? sel_count_one : sel_count_reg + sel_count_one;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_count_reg <= sel_count_rst;
        end else begin
            sel_count_reg <= sel_count_next;
        end
    end

    // ------------------------------------------------------------------
    // line driver enables
    // ------------------------------------------------------------------
    // no register in this path so the global enable cuts drivers at once
    generate
        for (genvar p = 0; p < num_ports; p++) begin : g_port
            // tristate bits act in host mode only; either source wins
            assign drv_active[p] = global_drv_en_i &&
                !(host_mode_i && port_driver_tristate_bit_reg[p]);
        end
    endgenerate

    assign line_out_tip_en_o = drv_active;
    assign line_out_ring_en_o = drv_active;

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    // decode and registers ignore the driver enable and keep working
    function automatic logic in_block(input logic [31:0] a);
        in_block = (a[31:8] == 24'h00_0000);
    endfunction

    function automatic logic is_word(input logic [2:0] s);
        is_word = (s == hsize_word);
    endfunction

    // unmapped offsets read zero
    function automatic logic [31:0] read_word(
            input logic [7:0] a,
            input logic [num_ports-1:0] tri_bits,
            input logic [31:0] status,
            input logic [15:0] count);
        read_word = 32'h0000_0000;
        if (addr_hit(a, drv_tristate_off)) begin
            read_word[num_ports-1:0] = tri_bits;
        end else if (addr_hit(a, cfg_status_off)) begin
            read_word = status;
        end else if (addr_hit(a, sel_count_off)) begin
            read_word[15:0] = count;
        end
    endfunction

    assign addr_phase = hsel_i && hready_i && is_transfer(htrans_i);
    // transfers outside the block or narrower than a word are answered, then dropped
    assign addr_ok = addr_phase && in_block(haddr_i) && is_word(hsize_i);
    assign wr_tristate = bus_req_reg.valid && bus_req_reg.write &&
        addr_hit(bus_req_reg.addr, drv_tristate_off);
    // any write to the counter clears it; the data word is not looked at
    assign wr_count_clear = bus_req_reg.valid && bus_req_reg.write &&
        addr_hit(bus_req_reg.addr, sel_count_off);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[st_host_mode_pos] = host_mode_i;
        status_word[st_unipolar_pos] = unipolar_i;
        status_word[st_drv_en_pos] = global_drv_en_i;
        status_word[st_sel_active_pos] = host_access_reg;
        status_word[st_cfg_pos +: $bits(line_cfg_type)] = line_cfg_reg;
        status_word[st_drv_active_pos +: num_ports] = drv_active;
    end

    // ------------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------------
    // the write of the data phase uses the address held here
    always_comb begin
        bus_req_next = bus_req_reg;
        if (hready_i) begin
            bus_req_next.valid = addr_ok;
            bus_req_next.write = hwrite_i;
            bus_req_next.addr = haddr_i[7:0];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_req_reg <= bus_req_rst;
        end else begin
            bus_req_reg <= bus_req_next;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // the word is taken in the address phase and stands through the data phase
    always_comb begin
        hrdata_next = hrdata_reg;
        if (hready_i) begin
            hrdata_next = 32'h0000_0000;
            if (addr_ok && !hwrite_i) begin
                hrdata_next = read_word(haddr_i[7:0], port_driver_tristate_bit_reg,
                    status_word, sel_count_reg);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hrdata_reg <= 32'h0000_0000;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    // ------------------------------------------------------------------
    // driver tristate register
    // ------------------------------------------------------------------
    // stored in either mode, but only host mode lets the bits act
    always_comb begin
        port_driver_tristate_bit_next = port_driver_tristate_bit_reg;
        if (wr_tristate) begin
            port_driver_tristate_bit_next = hwdata_i[num_ports-1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_driver_tristate_bit_reg <= drv_tristate_rst[num_ports-1:0];
        end else begin
            port_driver_tristate_bit_reg <= port_driver_tristate_bit_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hrdata_o = hrdata_reg;
    // zero wait states and never an error: unmapped words simply read zero
    assign hreadyout_o = 1'b1;
    assign hresp_o = hresp_okay;
    assign line_cfg_o = line_cfg_reg;
    assign host_access_o = host_access_reg;

endmodule

// ==== sim/strap_cfg_props.sv ====
// checker: strap decode, select watcher and driver enable assertions
`timescale 1ns/10ps
module strap_cfg_props
    import strap_cfg_pkg::*;
#(
    parameter int num_ports = 4
) (
    input wire logic mclk_i,                           // clock
    input wire logic arst_n_i,                         // reset, active low
    input wire logic host_mode_i,                      // mode pin
    input wire logic unipolar_i,                       // unipolar pin
    input wire logic host_select_n_i,                  // host select
    input wire logic attenuator_place_select_i,        // placement level
    input wire logic attenuator_place_float_i,         // placement open
    input wire logic bus_style_or_line_code_select_i,  // shared pin
    input wire logic global_drv_en_i,                  // global enable
    input line_cfg_type line_cfg_o,                    // decoded config
    input logic host_access_o,                         // select seen
    input logic [num_ports-1:0] line_out_tip_en_o,     // tip enables
    input logic [num_ports-1:0] line_out_ring_en_o     // ring enables
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence sel_fall;
        host_mode_i && host_select_n_i ##1 host_mode_i && !host_select_n_i;
    endsequence

    sel_fall_a: assert property (sel_fall |=> host_access_o)
        else $error("select fall not flagged");
    ja_place_a: assert property (arst_n_i && !host_mode_i && !attenuator_place_float_i
        |=> {line_cfg_o.ja_in_tx, line_cfg_o.ja_in_rx} ==
        {!$past(attenuator_place_select_i), $past(attenuator_place_select_i)})
        else $error("attenuator placement wrong");
    ja_off_a: assert property (attenuator_place_float_i || host_mode_i |=>
        !line_cfg_o.ja_in_tx && !line_cfg_o.ja_in_rx) else $error("attenuator not off");
    bus_style_a: assert property (arst_n_i && host_mode_i |=> !line_cfg_o.ami_en &&
        line_cfg_o.bus_rd_wr_style == $past(bus_style_or_line_code_select_i))
        else $error("bus style wrong");
    code_low_a: assert property (arst_n_i && !host_mode_i && unipolar_i &&
        !bus_style_or_line_code_select_i |=> line_cfg_o.zero_sub_en && !line_cfg_o.ami_en)
        else $error("zero substitution not selected");
    code_high_a: assert property (arst_n_i && !host_mode_i && unipolar_i &&
        bus_style_or_line_code_select_i |=> line_cfg_o.ami_en && !line_cfg_o.zero_sub_en)
        else $error("plain code not selected");
    drv_off_a: assert property (!global_drv_en_i |->
        line_out_tip_en_o == '0 && line_out_ring_en_o == '0) else $error("driver left on");
    keep_on_a: assert property (sel_fall ##0 !global_drv_en_i |=> host_access_o)
        else $error("host side stopped");
    pair_en_a: assert property (line_out_tip_en_o == line_out_ring_en_o)
        else $error("tip and ring differ");
    hw_drv_a: assert property (!host_mode_i && global_drv_en_i |-> &line_out_tip_en_o)
        else $error("driver off in hardware mode");
endmodule

bind strap_config_and_driver_enable strap_cfg_props #(.num_ports(num_ports)) props_i (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .host_mode_i(host_mode_i),
    .unipolar_i(unipolar_i), .host_select_n_i(host_select_n_i),
    .attenuator_place_select_i(attenuator_place_select_i),
    .attenuator_place_float_i(attenuator_place_float_i),
    .bus_style_or_line_code_select_i(bus_style_or_line_code_select_i),
    .global_drv_en_i(global_drv_en_i), .line_cfg_o(line_cfg_o),
    .host_access_o(host_access_o), .line_out_tip_en_o(line_out_tip_en_o),
    .line_out_ring_en_o(line_out_ring_en_o));

// ==== sim/strap_host_model.sv ====
// far-side model: board straps and host select pin
`timescale 1ns/10ps
module strap_host_model (
    input wire logic mclk_i,          // clock
    input wire logic [3:0] strap_i,   // mode, unipolar, placement, code
    input wire logic float_i,         // placement pin left open
    input wire logic access_i,        // host access in progress
    output logic host_mode_o = 1'b0,  // mode pin
    output logic unipolar_o = 1'b0,   // unipolar pin
    output logic place_o = 1'b0,      // placement pin level
    output logic float_o = 1'b0,      // placement pin open
    output logic code_o = 1'b0,       // shared style or code pin
    output logic sel_n_o = 1'b1       // host select, active low
);
    always @(posedge mclk_i) begin
        host_mode_o <= strap_i[3];
        unipolar_o <= strap_i[2];
        // an open pin shows no stable level
        place_o <= float_i ? ~place_o : strap_i[1];
        float_o <= float_i;
        code_o <= strap_i[0];
        sel_n_o <= ~(access_i & strap_i[3]);
    end
endmodule

// ==== sim/testbench.sv ====
// testbench: straps, host select counter and driver tristate control
`timescale 1ns/10ps
module testbench;
    import strap_cfg_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic drv_en = 1'b1, hsel = 1'b0, hwrite = 1'b0, flt = 1'b0, acc = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [3:0] strap = 4'h0;
    wire logic hmode, uni, seln, place, pflt, code, rdy, hacc;
    wire logic [31:0] hrdata;
    wire logic [1:0] hresp;
    wire line_cfg_type cfg;
    wire logic [3:0] tip, ring;
    int err_total = 0, num_checks = 0;

    initial forever #2 mclk_i = ~mclk_i;

    strap_host_model far (.mclk_i(mclk_i), .strap_i(strap), .float_i(flt), .access_i(acc),
        .host_mode_o(hmode), .unipolar_o(uni), .place_o(place), .float_o(pflt),
        .code_o(code), .sel_n_o(seln));

    strap_config_and_driver_enable dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .host_mode_i(hmode), .unipolar_i(uni), .host_select_n_i(seln),
        .attenuator_place_select_i(place), .attenuator_place_float_i(pflt),
        .bus_style_or_line_code_select_i(code), .global_drv_en_i(drv_en), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy),
        .hresp_o(hresp), .line_cfg_o(cfg), .host_access_o(hacc),
        .line_out_tip_en_o(tip), .line_out_ring_en_o(ring));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (rdy !== 1'b1 && n < 64);
        if (rdy !== 1'b1) begin
            err_total++;
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= htrans_nonseq;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk(32'(hresp), 32'(hresp_okay));
    endtask

    task automatic t_straps;
        logic [31:0] rd;
        logic [4:0] e;
        for (int i = 0; i < 8; i++) begin
            strap <= {2'b01, i[0], i[1]};
            flt <= i[2];
            e = {~i[2] & ~i[0], ~i[2] & i[0], 1'b0, ~i[1], i[1]};
            cyc(3);
            chk(32'(cfg), 32'(e));
            bus(1'b0, cfg_status_off, 32'h0, rd);
            chk(32'(rd[12:8]), 32'(e));
        end
        $display("test straps done");
    endtask

    task automatic t_host;
        logic [31:0] rd;
        for (int b = 0; b < 2; b++) begin
            strap <= {3'b110, b[0]};
            cyc(3);
            chk(32'(cfg), {29'h0, b[0], 2'b00});
        end
        bus(1'b1, sel_count_off, 32'h0, rd);
        for (int k = 0; k < 3; k++) begin
            acc <= 1'b1;
            cyc(3);
            chk(32'(hacc), 32'h1);
            acc <= 1'b0;
            cyc(2);
        end
        bus(1'b0, sel_count_off, 32'h0, rd);
        chk(rd, 32'h3);
        bus(1'b1, sel_count_off, 32'h0, rd);
        bus(1'b0, sel_count_off, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test host done");
    endtask

    task automatic t_drv;
        logic [31:0] rd;
        bus(1'b0, drv_tristate_off, 32'h0, rd);
        chk(rd, 32'(drv_tristate_rst));
        bus(1'b1, drv_tristate_off, 32'h5, rd);
        cyc(1);
        chk(32'(tip), 32'ha);
        chk(32'(ring), 32'ha);
        drv_en <= 1'b0;
        acc <= 1'b1;
        cyc(3);
        chk(32'({tip, ring}), 32'h0);
        chk(32'(hacc), 32'h1);
        acc <= 1'b0;
        bus(1'b0, cfg_status_off, 32'h0, rd);
        chk(32'(rd[19:16]), 32'h0);
        drv_en <= 1'b1;
        strap <= 4'h4;
        cyc(3);
        chk(32'(tip), 32'hf);
        bus(1'b1, 8'h0c, 32'hffffffff, rd);
        bus(1'b0, 8'h0c, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b0, drv_tristate_off, 32'h0, rd);
        chk(rd, 32'h5);
        $display("test drivers done");
    endtask

    initial begin
        cyc(5);
        arst_n_i <= 1'b1;
        t_straps();
        t_host();
        t_drv();
        wrap_up();
    end
endmodule
